/* rtl/apc_top.sv */
// analog pll control: input mux, feedback word, phase steps, spread, outputs
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "apc_params.svh"

module apc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [3:0]  gpio_in,
  input  wire logic [2:0]  clk_in_level,
  input  wire logic        osc_pin_level,
  input  wire logic        xtal_level,
  input  wire logic        dpll_clk_level,
  input  wire logic        vco_lock_in,
  input  wire logic        vco_lock_secondary_in,
  output logic             pll_ref_clk,
  output logic [2:0]       pll_ref_select,
  output logic             cascade_mode,
  output logic             analog_loop_on,
  output logic             relock_pulse,
  output logic [41:0]      fb_word,
  output logic [5:0]       fb_frac_bits,
  output logic [31:0]      fb_remainder,
  output logic [31:0]      fb_denominator,
  output logic [7:0]       post_divider_one,
  output logic [7:0]       post_divider_two,
  output logic             phase_up_pulse,
  output logic             phase_down_pulse,
  output logic             loop_bypass,
  output logic [39:0]      osc_freq_word,
  output logic [2:0]       out_p_drive_en,
  output logic [2:0]       out_n_drive_en,
  output logic [2:0]       out_n_invert,
  output logic [2:0]       out_clk_invert,
  output logic [5:0]       out_drive_strength,
  output logic [2:0]       out_low_power,
  output logic [2:0]       out_divider_run
);

  // ****************************************
  // register masks
  // ****************************************
  localparam logic [`APC_NREG-1:0][31:0] WMASK = {
    `APC_MASK_SSCTL, `APC_MASK_FREQ_HI, 32'hffff_ffff, `APC_MASK_MODE,
    `APC_MASK_OUTEN, `APC_MASK_OUTFMT, `APC_MASK_PHASE, 32'h0000_0000,
    `APC_MASK_POSTDIV, `APC_MASK_FB_BP, 32'hffff_ffff, 32'hffff_ffff,
    `APC_MASK_FB_HI, `APC_MASK_FB_LO, `APC_MASK_INCTL, `APC_MASK_MASTER_CONTROL_REG_TWO,
    `APC_MASK_INSEL, `APC_MASK_ENABLE};

  localparam logic [16:0] SS_INC = 17'(`APC_SS_INC_PER_KHZ);

  apc_pkg::apc_state_t st_r;
  apc_pkg::apc_state_t st_nxt;

  // step source: 0 selects the register bit, 1..4 a synchronised gpio
  function automatic logic src_level(input logic [2:0] src, input logic regbit,
                                     input logic [3:0] gp);
    logic lvl;
    lvl = regbit;
    if (src >= 3'h1 && src <= 3'h4) begin
      lvl = gp[2'(src - 3'h1)];
    end
    return lvl;
  endfunction : src_level

  // ****************************************
  // next state
  // ****************************************
  logic [4:0]        widx;
  logic [4:0]        ridx;
  logic [2:0]        sel_eff;
  logic [2:0]        ic_lvl;
  logic [2:0]        ic_div;
  logic              up_lvl;
  logic              dn_lvl;
  logic              up_edge;
  logic              dn_edge;
  logic [5:0]        rate;
  logic [9:0]        tri_ph;
  logic [8:0]        tri_u;
  logic signed [9:0] tri_s;
  logic [39:0]       base;
  logic [39:0]       dev_lim;
  logic [15:0]       dev;
  logic signed [26:0] off_full;
  logic signed [18:0] off;
  logic [5:0]        bp;
  logic [5:0]        int_bits;
  logic [41:0]       fb_mask;
  logic [2:0]        fmt;
  logic [31:0]       merged;

  always_comb begin
    st_nxt   = st_r;
    widx     = st_r.awaddr[6:2];
    ridx     = araddr[6:2];
    merged   = 32'h0000_0000;

    // ---- axi4-lite write
    if (awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr  = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata  = wdata;
      st_nxt.wstrb  = wstrb;
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = 2'b10;
      if (st_r.awaddr[7] == 1'b0 && widx < 5'(`APC_NREG)) begin
        st_nxt.bresp = 2'b00;
        for (int b = 0; b < 4; b++) begin
          merged[b*8 +: 8] = st_r.wstrb[b] ? st_r.wdata[b*8 +: 8]
                                           : st_r.regs[widx][b*8 +: 8];
        end
        st_nxt.regs[widx] = merged & WMASK[widx];
      end
    end
    st_nxt.awready = !st_nxt.aw_have;
    st_nxt.wready  = !st_nxt.w_have;

    // ---- axi4-lite read
    if (arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rresp   = 2'b10;
      st_nxt.rdata   = 32'h0000_0000;
      if (araddr[7] == 1'b0 && ridx < 5'(`APC_NREG)) begin
        st_nxt.rresp = 2'b00;
        st_nxt.rdata = st_r.regs[ridx] & WMASK[ridx];
        if (ridx == `APC_IDX_STATUS) begin
          st_nxt.rdata = {21'h0, st_r.phase_pos, 6'h0, st_r.lock2, st_r.lock};
        end
      end
    end else if (st_r.rvalid && rready) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end else if (!st_r.rvalid) begin
      st_nxt.arready = 1'b1;
    end

    // ---- gpio synchronisers
    st_nxt.gpio_s1 = gpio_in;
    st_nxt.gpio_s2 = st_r.gpio_s1;

    // ---- clock inputs: polarity then prescaler
    for (int i = 0; i < 3; i++) begin
      ic_lvl[i] = clk_in_level[i] ^ st_r.regs[`APC_IDX_INCTL][i*8 + 2];
      if (ic_lvl[i] && !st_r.ic_prev[i]) begin
        st_nxt.ic_cnt[i] = st_r.ic_cnt[i] + 3'h1;
      end
      unique case (st_r.regs[`APC_IDX_INCTL][i*8 +: 2])
        2'h0: ic_div[i] = ic_lvl[i];
        2'h1: ic_div[i] = st_r.ic_cnt[i][0];
        2'h2: ic_div[i] = st_r.ic_cnt[i][1];
        2'h3: ic_div[i] = st_r.ic_cnt[i][2];
      endcase
    end
    st_nxt.ic_prev = ic_lvl;

    // ---- reference mux
    sel_eff = st_r.regs[`APC_IDX_INSEL][2:0];
    if (st_r.regs[`APC_IDX_INSEL][`APC_INSEL_EXT_BIT] &&
        st_r.gpio_s2[st_r.regs[`APC_IDX_MASTER_CONTROL_REG_TWO][1:0]]) begin
      sel_eff = st_r.regs[`APC_IDX_INSEL][`APC_INSEL_ALT_LSB +: 3];
    end
    unique case (sel_eff)
      3'h0, 3'h1, 3'h2: st_nxt.ref_clk = ic_div[2'(sel_eff)];
      3'h3:             st_nxt.ref_clk = osc_pin_level;
      3'h4, 3'h5:       st_nxt.ref_clk = xtal_level;
      3'h6, 3'h7:       st_nxt.ref_clk = dpll_clk_level;
    endcase
    st_nxt.ref_sel = sel_eff;
    st_nxt.cascade = (sel_eff[2:1] == 2'b11);

    // ---- enable, relock, lock status
    st_nxt.loop_on = st_r.regs[`APC_IDX_ENABLE][0];
    st_nxt.relock  = st_nxt.loop_on && !st_r.loop_on;
    st_nxt.lock    = st_r.loop_on && vco_lock_in;
    st_nxt.lock2   = st_r.loop_on && vco_lock_secondary_in;

    // ---- feedback divider word
    bp = st_r.regs[`APC_IDX_FB_BP][5:0];
    if (bp > `APC_FB_FRAC_MAX) begin
      bp = `APC_FB_FRAC_MAX;
    end
    int_bits = st_nxt.cascade ? 6'd7 : 6'd9;
    st_nxt.fb_shift = `APC_FB_FRAC_MAX - bp;
    fb_mask = ~({42{1'b1}} << (st_nxt.fb_shift + int_bits));
    st_nxt.fb_word = {st_r.regs[`APC_IDX_FB_HI][9:0], st_r.regs[`APC_IDX_FB_LO]} & fb_mask;

    // ---- phase steps, both edges, shared by both post-dividers
    up_lvl = src_level(st_r.regs[`APC_IDX_PHASE][`APC_PHASE_UP_LSB +: 3],
                       st_r.regs[`APC_IDX_PHASE][`APC_PHASE_UPBIT], st_r.gpio_s2);
    dn_lvl = src_level(st_r.regs[`APC_IDX_PHASE][2:0],
                       st_r.regs[`APC_IDX_PHASE][`APC_PHASE_DNBIT], st_r.gpio_s2);
    up_edge = up_lvl ^ st_r.up_prev;
    dn_edge = dn_lvl ^ st_r.dn_prev;
    st_nxt.up_prev  = up_lvl;
    st_nxt.dn_prev  = dn_lvl;
    st_nxt.up_pulse = up_edge && !dn_edge;
    st_nxt.dn_pulse = dn_edge && !up_edge;
    if (st_nxt.up_pulse) begin
      st_nxt.phase_pos = st_r.phase_pos + 3'h1;
    end else if (st_nxt.dn_pulse) begin
      st_nxt.phase_pos = st_r.phase_pos - 3'h1;
    end

    // ---- oscillator word and spread modulation
    base = {st_r.regs[`APC_IDX_FREQ_HI][7:0], st_r.regs[`APC_IDX_FREQ_LO]};
    rate = st_r.regs[`APC_IDX_SSCTL][5:0];
    if (rate < `APC_SS_RATE_MIN) begin
      rate = `APC_SS_RATE_MIN;
    end else if (rate > `APC_SS_RATE_MAX) begin
      rate = `APC_SS_RATE_MAX;
    end
    dev_lim = (base >> 8) + (base >> 10);
    dev     = st_r.regs[`APC_IDX_SSCTL][`APC_SS_DEV_LSB +: 16];
    if (dev_lim < 40'(dev)) begin
      dev = dev_lim[15:0];
    end
    tri_ph   = st_r.ss_acc[31:22];
    tri_u    = tri_ph[9] ? ~tri_ph[8:0] : tri_ph[8:0];
    tri_s    = $signed({1'b0, tri_u}) - 10'sd256;
    off_full = $signed({11'h000, dev}) * 27'(tri_s);
    off      = 19'(off_full >>> 8);
    st_nxt.loop_bypass = st_r.regs[`APC_IDX_MODE][0] || st_r.regs[`APC_IDX_MODE][1];
    if (st_r.regs[`APC_IDX_MODE][1]) begin
      st_nxt.ss_acc    = st_r.ss_acc + 32'(rate * SS_INC);
      st_nxt.freq_word = base + 40'($signed(off));
    end else begin
      st_nxt.ss_acc    = 32'h0000_0000;
      st_nxt.freq_word = base;
    end

    // ---- output driver controls
    for (int o = 0; o < 3; o++) begin
      fmt = st_r.regs[`APC_IDX_OUTFMT][o*8 +: 3];
      st_nxt.p_en[o]      = (fmt != apc_pkg::APC_FMT_OFF) &&
                            (fmt != apc_pkg::APC_FMT_RSVD);
      st_nxt.low_power[o] = !st_nxt.p_en[o];
      st_nxt.n_en[o]      = st_nxt.p_en[o] && (fmt != apc_pkg::APC_FMT_CMOS_P);
      st_nxt.n_inv[o]     = st_nxt.n_en[o] && (fmt != apc_pkg::APC_FMT_CMOS_IN);
      st_nxt.clk_inv[o]   = st_r.regs[`APC_IDX_OUTFMT][o*8 + 3];
      st_nxt.drive[o*2 +: 2] = st_r.regs[`APC_IDX_OUTFMT][o*8 + 4 +: 2];
      st_nxt.div_run[o]   = st_r.regs[`APC_IDX_OUTEN][o];
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.regs[`APC_IDX_FB_BP]   <= `APC_RST_FB_BP;
      st_r.regs[`APC_IDX_POSTDIV] <= `APC_RST_POSTDIV;
      st_r.regs[`APC_IDX_SSCTL]   <= `APC_RST_SSCTL;
      st_r.low_power              <= 3'h7;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs, all straight from flops
  // ****************************************
  assign awready            = st_r.awready;
  assign wready             = st_r.wready;
  assign bvalid             = st_r.bvalid;
  assign bresp              = st_r.bresp;
  assign arready            = st_r.arready;
  assign rvalid             = st_r.rvalid;
  assign rdata              = st_r.rdata;
  assign rresp              = st_r.rresp;
  assign pll_ref_clk        = st_r.ref_clk;
  assign pll_ref_select     = st_r.ref_sel;
  assign cascade_mode       = st_r.cascade;
  assign analog_loop_on     = st_r.loop_on;
  assign relock_pulse       = st_r.relock;
  assign fb_word            = st_r.fb_word;
  assign fb_frac_bits       = st_r.fb_shift;
  assign fb_remainder       = st_r.regs[`APC_IDX_FB_REM];
  assign fb_denominator     = st_r.regs[`APC_IDX_FB_DEN];
  assign post_divider_one   = st_r.regs[`APC_IDX_POSTDIV][7:0];
  assign post_divider_two   = st_r.regs[`APC_IDX_POSTDIV][15:8];
  assign phase_up_pulse     = st_r.up_pulse;
  assign phase_down_pulse   = st_r.dn_pulse;
  assign loop_bypass        = st_r.loop_bypass;
  assign osc_freq_word      = st_r.freq_word;
  assign out_p_drive_en     = st_r.p_en;
  assign out_n_drive_en     = st_r.n_en;
  assign out_n_invert       = st_r.n_inv;
  assign out_clk_invert     = st_r.clk_inv;
  assign out_drive_strength = st_r.drive;
  assign out_low_power      = st_r.low_power;
  assign out_divider_run    = st_r.div_run;

endmodule : apc_top

/* shared/apc_params.svh */
// constants for the analog pll control block
`ifndef APC_PARAMS_SVH
`define APC_PARAMS_SVH

// ****************************************
// register map
// ****************************************
`define APC_NREG          18
`define APC_IDX_ENABLE    5'd0
`define APC_IDX_INSEL     5'd1
`define APC_IDX_MASTER_CONTROL_REG_TWO      5'd2
`define APC_IDX_INCTL     5'd3
`define APC_IDX_FB_LO     5'd4
`define APC_IDX_FB_HI     5'd5
`define APC_IDX_FB_REM    5'd6
`define APC_IDX_FB_DEN    5'd7
`define APC_IDX_FB_BP     5'd8
`define APC_IDX_POSTDIV   5'd9
`define APC_IDX_STATUS    5'd10
`define APC_IDX_PHASE     5'd11
`define APC_IDX_OUTFMT    5'd12
`define APC_IDX_OUTEN     5'd13
`define APC_IDX_MODE      5'd14
`define APC_IDX_FREQ_LO   5'd15
`define APC_IDX_FREQ_HI   5'd16
`define APC_IDX_SSCTL     5'd17

// writable bits per register
`define APC_MASK_ENABLE   32'h0000_0001
`define APC_MASK_INSEL    32'h0000_0177
`define APC_MASK_MASTER_CONTROL_REG_TWO     32'h0000_0003
`define APC_MASK_INCTL    32'h0007_0707
`define APC_MASK_FB_LO    32'hffff_ffff
`define APC_MASK_FB_HI    32'h0000_03ff
`define APC_MASK_FB_BP    32'h0000_003f
`define APC_MASK_POSTDIV  32'h0000_ffff
`define APC_MASK_PHASE    32'h0000_0377
`define APC_MASK_OUTFMT   32'h003f_3f3f
`define APC_MASK_OUTEN    32'h0000_0007
`define APC_MASK_MODE     32'h0000_0003
`define APC_MASK_FREQ_HI  32'h0000_00ff
`define APC_MASK_SSCTL    32'hffff_003f

// reset values
`define APC_RST_FB_BP     32'h0000_0009
`define APC_RST_POSTDIV   32'h0000_0606
`define APC_RST_SSCTL     32'h0000_0019

// field positions
`define APC_INSEL_ALT_LSB   4
`define APC_INSEL_EXT_BIT   8
`define APC_PHASE_UP_LSB    4
`define APC_PHASE_DNBIT     8
`define APC_PHASE_UPBIT     9
`define APC_STATUS_POS_LSB  8
`define APC_SS_DEV_LSB      16

// ****************************************
// timing
// ****************************************
`define APC_CLK_HZ        64'd50000000
`define APC_SS_RATE_MIN   6'd25
`define APC_SS_RATE_MAX   6'd55
// accumulator step per kHz of modulation rate: 1000 * 2^32 / clock
`define APC_SS_INC_PER_KHZ (64'd4294967296000 / `APC_CLK_HZ)
`define APC_FB_FRAC_MAX   6'd33

`endif

/* shared/apc_pkg.sv */
// types for the analog pll control block
package apc_pkg;
`include "apc_params.svh"

  typedef enum logic [2:0] {
    APC_FMT_OFF      = 3'h0,
    APC_FMT_CML      = 3'h1,
    APC_FMT_CML_HALF = 3'h2,
    APC_FMT_HSTL     = 3'h3,
    APC_FMT_CMOS_P   = 3'h4,
    APC_FMT_CMOS_IN  = 3'h5,
    APC_FMT_CMOS_INV = 3'h6,
    APC_FMT_RSVD     = 3'h7
  } apc_fmt_t;

  typedef struct packed {
    logic [`APC_NREG-1:0][31:0] regs;
    logic                       aw_have;
    logic                       w_have;
    logic [7:0]                 awaddr;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic [3:0]                 gpio_s1;
    logic [3:0]                 gpio_s2;
    logic                       up_prev;
    logic                       dn_prev;
    logic                       up_pulse;
    logic                       dn_pulse;
    logic [2:0]                 phase_pos;
    logic [2:0]                 ic_prev;
    logic [2:0][2:0]            ic_cnt;
    logic                       ref_clk;
    logic [2:0]                 ref_sel;
    logic                       cascade;
    logic                       loop_on;
    logic                       relock;
    logic                       lock;
    logic                       lock2;
    logic                       loop_bypass;
    logic [31:0]                ss_acc;
    logic [39:0]                freq_word;
    logic [41:0]                fb_word;
    logic [5:0]                 fb_shift;
    logic [2:0]                 p_en;
    logic [2:0]                 n_en;
    logic [2:0]                 n_inv;
    logic [2:0]                 clk_inv;
    logic [5:0]                 drive;
    logic [2:0]                 low_power;
    logic [2:0]                 div_run;
  } apc_state_t;

endpackage : apc_pkg

/* sim/apc_top_asserts.sv */
// concurrent checks on the analog pll control block ports
`timescale 1ns/1ps
module apc_top_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        arready,
  input wire logic [2:0]  pll_ref_select,
  input wire logic        cascade_mode,
  input wire logic        analog_loop_on,
  input wire logic        relock_pulse,
  input wire logic [41:0] fb_word,
  input wire logic [5:0]  fb_frac_bits,
  input wire logic        phase_up_pulse,
  input wire logic        phase_down_pulse,
  input wire logic [2:0]  out_p_drive_en,
  input wire logic [2:0]  out_n_drive_en,
  input wire logic [2:0]  out_low_power
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // bus and control relations
  // ****************************************
  sequence rd_done_s; rvalid && rready; endsequence
  sequence rd_reopen_s; !rvalid && arready; endsequence
  read_refuse_a: assert property (rvalid |-> !arready) else $error("read address taken early");
  read_close_a: assert property (rd_done_s |=> rd_reopen_s) else $error("read did not close");
  write_close_a: assert property (bvalid && bready |=> !bvalid) else $error("write resp stuck");
  relock_on_a: assert property (relock_pulse |-> ##[0:2] analog_loop_on)
    else $error("relock while loop off");
  relock_once_a: assert property (relock_pulse |=> !relock_pulse)
    else $error("relock pulse too long");
  step_single_a: assert property (phase_up_pulse |=> !phase_up_pulse)
    else $error("up step pulse too long");
  step_excl_a: assert property (!(phase_up_pulse && phase_down_pulse))
    else $error("up and down step together");
  cascade_code_a: assert property (cascade_mode == (pll_ref_select[2:1] == 2'b11))
    else $error("cascade flag wrong");
  frac_limit_a: assert property (fb_frac_bits <= 6'd33)
    else $error("fraction bits above limit");
  fb_width_a: assert property ($stable(fb_frac_bits) |-> (fb_word >> (fb_frac_bits + 6'd9)) == 42'h0)
    else $error("feedback word too wide");
  idle_driver_a: assert property ((out_low_power & (out_p_drive_en | out_n_drive_en)) == 3'h0)
    else $error("low power output driving");
  n_follows_p_a: assert property ((out_n_drive_en & ~out_p_drive_en) == 3'h0)
    else $error("negative pin without positive");
endmodule : apc_top_checker

bind apc_top apc_top_checker u_apc_top_checker (.aclk(aclk), .aresetn(aresetn),
  .bvalid(bvalid), .bready(bready), .rvalid(rvalid), .rready(rready), .arready(arready),
  .pll_ref_select(pll_ref_select), .cascade_mode(cascade_mode),
  .analog_loop_on(analog_loop_on), .relock_pulse(relock_pulse), .fb_word(fb_word),
  .fb_frac_bits(fb_frac_bits), .phase_up_pulse(phase_up_pulse),
  .phase_down_pulse(phase_down_pulse), .out_p_drive_en(out_p_drive_en),
  .out_n_drive_en(out_n_drive_en), .out_low_power(out_low_power));

/* sim/test_apc_top.sv */
// self-checking bench for the analog pll control block
`timescale 1ns/1ps
module test_apc_top;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, bvalid, rvalid, awready, wready, arready, lock = 1, lk2 = 0;
  logic        ref_clk, casc, loop_on, relock, up_p, dn_p, bypass, rc_q = 0;
  logic [7:0]  awaddr = '0, araddr = '0, pd1, pd2;
  logic [31:0] wdata = '0, rdata, v, p0, r = 32'h0000_0007, frem, fden;
  logic [3:0]  gpio = '0;
  logic [2:0]  cin = '0, sel, pen, nen, ninv, cinv, lowp, drun;
  logic [1:0]  bresp, rresp, rs;
  logic [41:0] fbw;
  logic [5:0]  frac, drv;
  logic [39:0] fword, lo, hi;
  int          mismatches = 0, n_compared = 0, n_up = 0, n_dn = 0, n_rl = 0, n_rc = 0;

  apc_top u_apc_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .gpio_in(gpio), .clk_in_level(cin), .osc_pin_level(1'b0), .xtal_level(1'b0),
    .dpll_clk_level(1'b0), .vco_lock_in(lock), .vco_lock_secondary_in(lk2),
    .pll_ref_clk(ref_clk), .pll_ref_select(sel), .cascade_mode(casc),
    .analog_loop_on(loop_on), .relock_pulse(relock), .fb_word(fbw), .fb_frac_bits(frac),
    .fb_remainder(frem), .fb_denominator(fden), .post_divider_one(pd1), .post_divider_two(pd2),
    .phase_up_pulse(up_p), .phase_down_pulse(dn_p), .loop_bypass(bypass),
    .osc_freq_word(fword), .out_p_drive_en(pen), .out_n_drive_en(nen), .out_n_invert(ninv),
    .out_clk_invert(cinv), .out_drive_strength(drv), .out_low_power(lowp),
    .out_divider_run(drun));

  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    if (up_p === 1'b1) n_up++;
    if (dn_p === 1'b1) n_dn++;
    if (relock === 1'b1) n_rl++;
    if (ref_clk === 1'b1 && rc_q === 1'b0) n_rc++;
    rc_q <= ref_clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected feedback word: bits at and above fraction plus integer width cleared
  function automatic logic [41:0] fbx(input logic [31:0] lo, input logic [9:0] hi,
                                      input int bp, input int ib);
    int n = 33 - (bp > 33 ? 33 : bp) + ib;
    return {hi, lo} & ((42'h1 << n) - 42'h1);
  endfunction : fbx
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic st;
    repeat (6) @(posedge aclk);
  endtask : st
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    finish_test;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(lowp, 3'h7);
    chk({pd2, pd1}, 16'h0606);
    rd(8'h20, v);
    chk(v, 32'h0000_0009);
    rd(8'h28, v);
    chk(v[1:0], 2'h0);
    rd(8'h48, v);
    chk({rs, v}, {2'h2, 32'h0000_0000});
    wr(8'h48, 32'hffff_ffff);
    chk(rs, 2'h2);
    $display("reset and map test done");
    wr(8'h00, 32'h0000_0001);
    st;
    chk(loop_on, 1'b1);
    rd(8'h28, v);
    chk(v[1:0], 2'h1);
    lk2 <= 1'b1;
    st;
    rd(8'h28, v);
    chk(v[1:0], 2'h3);
    wr(8'h00, 32'h0000_0000);
    wr(8'h00, 32'h0000_0001);
    st;
    chk(n_rl, 2);
    $display("enable test done");
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      wr(8'h04, 2 * i);
      wr(8'h10, r);
      wr(8'h14, {22'h0, r[25:16]});
      wr(8'h18, ~r);
      wr(8'h1c, r + 32'h1);
      wr(8'h20, i * 11 + 7);
      st;
      chk(fbw, fbx(r, r[25:16], i * 11 + 7, i == 3 ? 7 : 9));
      chk({frem, fden}, {~r, r + 32'h1});
    end
    $display("feedback test done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h04, c);
      st;
      chk(sel, c[2:0]);
      chk(casc, c >= 6);
    end
    r = lfsr(r);
    wr(8'h08, 32'h0000_0002);
    wr(8'h04, {23'h0, 1'b1, 1'b0, r[6:4], 1'b0, r[2:0]});
    gpio <= 4'h2;
    st;
    chk(sel, r[2:0]);
    gpio <= 4'h4;
    st;
    chk(sel, r[6:4]);
    gpio <= 4'h0;
    wr(8'h04, 32'h0000_0000);
    cin <= 3'h1;
    wr(8'h0c, 32'h0000_0004);
    st;
    chk(ref_clk, 1'b0);
    wr(8'h0c, 32'h0000_0000);
    st;
    chk(ref_clk, 1'b1);
    // 16 input rises through each prescaler setting
    for (int p = 0; p < 4; p++) begin
      wr(8'h0c, p);
      st;
      n_rc = 0;
      repeat (32) begin
        cin[0] <= ~cin[0];
        repeat (2) @(posedge aclk);
      end
      st;
      chk(n_rc, 16 >> p);
    end
    $display("mux test done");
    wr(8'h2c, 32'h0000_0000);
    st;
    rd(8'h28, p0);
    n_up = 0;
    wr(8'h2c, 32'h0000_0200);
    wr(8'h2c, 32'h0000_0000);
    st;
    chk(n_up, 2);
    rd(8'h28, v);
    chk(v[10:8], p0[10:8] + 3'h2);
    wr(8'h2c, 32'h0000_0021);
    st;
    rd(8'h28, p0);
    n_up = 0;
    n_dn = 0;
    gpio <= 4'h2;
    st;
    gpio <= 4'h0;
    st;
    gpio <= 4'h1;
    st;
    chk(n_up, 2);
    chk(n_dn, 1);
    rd(8'h28, v);
    chk(v[10:8], p0[10:8] + 3'h1);
    $display("phase test done");
    wr(8'h34, 32'h0000_0007);
    for (int f = 0; f < 8; f++) begin
      wr(8'h30, {26'h0, f[1:0], f[0], f[2:0]});
      st;
      chk(pen[0], f != 0 && f != 7);
      chk(lowp[0], f == 0 || f == 7);
      chk(nen[0], f != 0 && f != 7 && f != 4);
      chk(ninv[0], f == 6 || (f >= 1 && f <= 3));
      chk({cinv[0], drv[1:0]}, {f[0], f[1:0]});
      chk(drun[0], 1'b1);
    end
    $display("output test done");
    r = lfsr(r);
    wr(8'h3c, r);
    wr(8'h40, {24'h0, r[31:24]});
    wr(8'h38, 32'h0000_0001);
    st;
    chk({bypass, fword}, {1'b1, r[31:24], r});
    wr(8'h40, 32'h0000_0001);
    wr(8'h44, 32'h0400_0019);
    wr(8'h38, 32'h0000_0002);
    lo = '1;
    hi = '0;
    // one full sweep at 25 kHz is 2000 clocks
    repeat (2000) begin
      @(posedge aclk);
      if (fword < lo) lo = fword;
      if (fword > hi) hi = fword;
    end
    chk(bypass, 1'b1);
    chk(lo, {8'h01, r} - 40'd1024);
    chk(hi > {8'h01, r} && hi <= {8'h01, r} + 40'd1024, 1'b1);
    wr(8'h24, 32'h0000_0a05);
    st;
    chk({pd2, pd1}, 16'h0a05);
    $display("mode test done");
    finish_test;
  end
endmodule : test_apc_top
